/* File: hw/swbx_defs.svh */
`ifndef SWBX_DEFS_SVH
`define SWBX_DEFS_SVH

// opcodes of the status-word group
`define SWBX_OP_PRESET_UPPER 8'h76
`define SWBX_OP_PRESET_LOWER 8'h77
`define SWBX_OP_CLEAR_UPPER 8'h74
`define SWBX_OP_CLEAR_LOWER 8'h75
`define SWBX_OP_TEST_UPPER 8'hb4
`define SWBX_OP_TEST_LOWER 8'hb5

// conditional branches: upper six opcode bits, low two bits are the v field
`define SWBX_OP6_TRUE_REL 6'h06
`define SWBX_OP6_TRUE_ABS 6'h07
`define SWBX_OP6_FALSE_REL 6'h26
`define SWBX_OP6_FALSE_ABS 6'h27
`define SWBX_V_ALWAYS 2'h3

// status bit layout
`define SWBX_UPPER_WRITABLE 8'he7
`define SWBX_CC_HI 7
`define SWBX_CC_LO 6
`define SWBX_CC_ALL_ONES 2'h0
`define SWBX_CC_NOT_ALL 2'h2
`define SWBX_UPPER_RST 8'h00
`define SWBX_LOWER_RST 8'h00

// operand byte fields
`define SWBX_IND_BIT 7
`define SWBX_DISP_SIGN 6
`define SWBX_LEN_REL 13'h0002
`define SWBX_LEN_ABS 13'h0003
`define SWBX_ADDR_ONE 13'h0001

// schedule: three machine cycles of three clock periods each
`define SWBX_CLK_PER_CYCLE 3
`define SWBX_INSTR_CYCLES 3
`define SWBX_LAST_EDGE (`SWBX_CLK_PER_CYCLE * `SWBX_INSTR_CYCLES - 1)
`define SWBX_E_FETCH2 4'h1
`define SWBX_E_CAP1 4'h2
`define SWBX_E_CAP2 4'h3
`define SWBX_E_IND_HI 4'h4
`define SWBX_E_IND_LO 4'h5
`define SWBX_E_CAP_HI 4'h6
`define SWBX_E_RESOLVE 4'h7
`define SWBX_CNT_FIRST 4'h1
`define SWBX_CNT_ZERO 4'h0

`endif

/* File: hw/swbx_pkg.sv */
package swbx_pkg;

   typedef enum logic {
      swbx_idle,
      swbx_run
   } swbx_state_type;

   typedef struct packed {
      logic [7:0] upper;
      logic [7:0] lower;
   } swbx_status_type;

   typedef struct packed {
      logic rd;
      logic [14:0] addr;
   } swbx_mem_req_type;

endpackage

/* File: hw/swbx_exec.sv */
`timescale 1ns/1ns
`default_nettype none
`include "swbx_defs.svh"

module swbx_exec
   import swbx_pkg::*;
(
   input wire logic clk,
   input wire logic nrst,
   input wire logic start,
   input wire logic [7:0] opcode,
   input wire logic [14:0] opcode_addr,
   input wire logic [7:0] mem_rdata,
   input wire logic [7:0] index_value,
   input wire logic status_wr,
   input wire swbx_status_type status_in,
   output var logic busy_r,
   output var logic done_r,
   output var logic refused_r,
   output var swbx_mem_req_type mem_req_r,
   output var logic iar_load_r,
   output var logic [14:0] iar_r,
   output var swbx_status_type status_r
);

   ////////////////////////////////////////////////////////////////////////////
   // helpers

   // add within the current 8 KB page, page bits unchanged
   function automatic logic [14:0] page_add(input logic [14:0] base, input logic [12:0] off);
      logic [12:0] low;
      low = base[12:0] + off;
      return {base[14:13], low};
   endfunction

   // seven-bit signed displacement widened to page width
   function automatic logic [12:0] sext_disp(input logic [7:0] b);
      return {{6{b[`SWBX_DISP_SIGN]}}, b[6:0]};
   endfunction

   // status-word group opcode
   function automatic logic psw_op(input logic [7:0] op);
      return (op == `SWBX_OP_PRESET_UPPER) || (op == `SWBX_OP_PRESET_LOWER) ||
             (op == `SWBX_OP_CLEAR_UPPER) || (op == `SWBX_OP_CLEAR_LOWER) ||
             (op == `SWBX_OP_TEST_UPPER) || (op == `SWBX_OP_TEST_LOWER);
   endfunction

   // conditional branch group opcode, any v field
   function automatic logic branch_op(input logic [7:0] op);
      return (op[7:2] == `SWBX_OP6_TRUE_REL) || (op[7:2] == `SWBX_OP6_TRUE_ABS) ||
             (op[7:2] == `SWBX_OP6_FALSE_REL) || (op[7:2] == `SWBX_OP6_FALSE_ABS);
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // state

   swbx_state_type state_r;
   swbx_state_type state_nxt;
   logic [3:0] cnt_r;
   logic [3:0] cnt_nxt;
   logic [7:0] op_r;
   logic [14:0] base_r;
   logic [7:0] byte1_r;
   logic [7:0] byte2_r;
   logic [7:0] ind_hi_r;
   logic [14:0] tgt_r;
   logic take_r;

   ////////////////////////////////////////////////////////////////////////////
   // decode

   wire [5:0] op6 = op_r[7:2];
   wire [1:0] vfield = op_r[1:0];
   wire is_preset_u = (op_r == `SWBX_OP_PRESET_UPPER);
   wire is_preset_l = (op_r == `SWBX_OP_PRESET_LOWER);
   wire is_clear_u = (op_r == `SWBX_OP_CLEAR_UPPER);
   wire is_clear_l = (op_r == `SWBX_OP_CLEAR_LOWER);
   wire is_test_u = (op_r == `SWBX_OP_TEST_UPPER);
   wire is_test_l = (op_r == `SWBX_OP_TEST_LOWER);
   wire is_true_rel = (op6 == `SWBX_OP6_TRUE_REL);
   wire is_true_abs = (op6 == `SWBX_OP6_TRUE_ABS);
   wire v_always = (vfield == `SWBX_V_ALWAYS);
   wire is_false_rel = (op6 == `SWBX_OP6_FALSE_REL) && !v_always;
   wire is_false_abs = (op6 == `SWBX_OP6_FALSE_ABS) && !v_always;
   wire is_zero_rel = (op6 == `SWBX_OP6_FALSE_REL) && v_always;
   wire is_index_abs = (op6 == `SWBX_OP6_FALSE_ABS) && v_always;
   wire is_abs = is_true_abs || is_false_abs || is_index_abs;
   wire is_rel = is_true_rel || is_false_rel || is_zero_rel;
   wire is_branch = is_abs || is_rel;

   // same decode applied to the incoming opcode, for acceptance only
   wire in_psw = psw_op(opcode);
   wire in_br = branch_op(opcode);
   wire accept = (state_r == swbx_idle) && start && (in_psw || in_br);
   wire reject = start && !accept;

   ////////////////////////////////////////////////////////////////////////////
   // status word arithmetic

   wire [1:0] cc = status_r.lower[`SWBX_CC_HI:`SWBX_CC_LO];
   wire [7:0] mask = byte1_r;
   wire [7:0] upper_mask = mask & `SWBX_UPPER_WRITABLE;
   wire [7:0] upper_set = status_r.upper | upper_mask;
   wire [7:0] upper_clr = status_r.upper & ~upper_mask;
   wire [7:0] lower_set = status_r.lower | mask;
   wire [7:0] lower_clr = status_r.lower & ~mask;
   // upper bits four and three read as zero, so they take part as zeros
   wire [7:0] upper_seen = status_r.upper & `SWBX_UPPER_WRITABLE;
   wire test_src_ok = is_test_u ? ((upper_seen & mask) == mask)
                                : ((status_r.lower & mask) == mask);
   wire [1:0] test_cc = test_src_ok ? `SWBX_CC_ALL_ONES : `SWBX_CC_NOT_ALL;

   ////////////////////////////////////////////////////////////////////////////
   // branch condition and addresses

   wire cc_match = (vfield == cc) || v_always;
   wire take_now = ((is_true_rel || is_true_abs) && cc_match) ||
                   ((is_false_rel || is_false_abs) && (vfield != cc)) ||
                   is_zero_rel || is_index_abs;

   wire [12:0] disp = sext_disp(byte1_r);
   wire [14:0] rel_ea = page_add(base_r, `SWBX_LEN_REL + disp);
   wire [14:0] zero_ea = {2'b00, disp};
   // absolute operand from both captured bytes; memory data is stale by the pointer fetch
   wire [14:0] abs_ea = {byte1_r[6:0], byte2_r};
   wire [14:0] direct_ea = is_zero_rel ? zero_ea : rel_ea;
   wire indirect = byte1_r[`SWBX_IND_BIT];
   wire [14:0] pointer_ea = is_abs ? abs_ea : direct_ea;
   wire [14:0] fetched_ea = {ind_hi_r[6:0], mem_rdata};
   wire [14:0] plain_ea = is_abs ? {byte1_r[6:0], byte2_r} : direct_ea;
   wire [14:0] pre_index = indirect ? fetched_ea : plain_ea;
   // index applied after any indirection
   wire [14:0] final_ea = is_index_abs ? page_add(pre_index, {5'h00, index_value}) : pre_index;
   wire [12:0] len = is_abs ? `SWBX_LEN_ABS : `SWBX_LEN_REL;
   wire [14:0] fall_addr = page_add(base_r, len);
   wire [14:0] ptr_lo_addr = page_add(mem_req_r.addr, `SWBX_ADDR_ONE);

   ////////////////////////////////////////////////////////////////////////////
   // schedule

   wire last_edge = (cnt_r == 4'(`SWBX_LAST_EDGE));
   wire issue_byte2 = (state_r == swbx_run) && (cnt_r == `SWBX_E_FETCH2) && is_abs;
   wire cap1 = (state_r == swbx_run) && (cnt_r == `SWBX_E_CAP1);
   wire cap2 = (state_r == swbx_run) && (cnt_r == `SWBX_E_CAP2);
   wire issue_hi = (state_r == swbx_run) && (cnt_r == `SWBX_E_IND_HI) && is_branch && indirect;
   wire issue_lo = (state_r == swbx_run) && (cnt_r == `SWBX_E_IND_LO) && is_branch && indirect;
   wire cap_hi = (state_r == swbx_run) && (cnt_r == `SWBX_E_CAP_HI);
   wire resolve = (state_r == swbx_run) && (cnt_r == `SWBX_E_RESOLVE);
   wire finish = (state_r == swbx_run) && last_edge;

   always_comb begin
      state_nxt = state_r;
      cnt_nxt = cnt_r;
      case (state_r)
         swbx_idle: begin
            if (accept) begin
               state_nxt = swbx_run;
               cnt_nxt = `SWBX_CNT_FIRST;
            end
         end
         swbx_run: begin
            if (last_edge) begin
               state_nxt = swbx_idle;
               cnt_nxt = `SWBX_CNT_ZERO;
            end else begin
               cnt_nxt = cnt_r + `SWBX_CNT_FIRST;
            end
         end
         default: begin
            state_nxt = swbx_idle;
            cnt_nxt = `SWBX_CNT_ZERO;
         end
      endcase
   end

   // memory request for the next operand byte or indirect pointer byte
   swbx_mem_req_type req_nxt;
   wire [14:0] byte1_addr = page_add(opcode_addr, `SWBX_ADDR_ONE);
   wire [14:0] byte2_addr = page_add(base_r, `SWBX_LEN_REL);
   assign req_nxt.rd = accept || issue_byte2 || issue_hi || issue_lo;
   assign req_nxt.addr = accept ? byte1_addr :
                         issue_byte2 ? byte2_addr :
                         issue_hi ? pointer_ea :
                         issue_lo ? ptr_lo_addr : mem_req_r.addr;

   // status word next value
   swbx_status_type status_nxt;
   wire [7:0] lower_test = {test_cc, status_r.lower[5:0]};
   assign status_nxt.upper = !finish ? (status_wr ? (status_in.upper & `SWBX_UPPER_WRITABLE)
                                                  : status_r.upper) :
                             is_preset_u ? upper_set :
                             is_clear_u ? upper_clr : status_r.upper;
   assign status_nxt.lower = !finish ? (status_wr ? status_in.lower : status_r.lower) :
                             is_preset_l ? lower_set :
                             is_clear_l ? lower_clr :
                             (is_test_u || is_test_l) ? lower_test : status_r.lower;

   wire [14:0] iar_nxt = take_r ? tgt_r : fall_addr;

   ////////////////////////////////////////////////////////////////////////////
   // registers

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         state_r <= swbx_idle;
      end else begin
         state_r <= state_nxt;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         cnt_r <= `SWBX_CNT_ZERO;
      end else begin
         cnt_r <= cnt_nxt;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         op_r <= 8'h00;
      end else if (accept) begin
         op_r <= opcode;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         base_r <= 15'h0000;
      end else if (accept) begin
         base_r <= opcode_addr;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         byte1_r <= 8'h00;
      end else begin
         byte1_r <= cap1 ? mem_rdata : byte1_r;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         byte2_r <= 8'h00;
      end else begin
         byte2_r <= (cap2 && is_abs) ? mem_rdata : byte2_r;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         ind_hi_r <= 8'h00;
      end else begin
         ind_hi_r <= (cap_hi && indirect) ? mem_rdata : ind_hi_r;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         tgt_r <= 15'h0000;
      end else if (resolve) begin
         tgt_r <= final_ea;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         take_r <= 1'b0;
      end else if (resolve) begin
         take_r <= is_branch && take_now;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         mem_req_r <= '0;
      end else begin
         mem_req_r <= req_nxt;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         status_r.upper <= `SWBX_UPPER_RST;
         status_r.lower <= `SWBX_LOWER_RST;
      end else begin
         status_r <= status_nxt;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         busy_r <= 1'b0;
      end else begin
         busy_r <= (state_nxt == swbx_run);
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         done_r <= 1'b0;
      end else begin
         done_r <= finish;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         refused_r <= 1'b0;
      end else begin
         refused_r <= reject;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         iar_load_r <= 1'b0;
      end else begin
         iar_load_r <= finish && is_branch;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         iar_r <= 15'h0000;
      end else begin
         iar_r <= (finish && is_branch) ? iar_nxt : iar_r;
      end
   end

endmodule
`default_nettype wire

/* File: sim/swbx_exec_properties.sv */
`timescale 1ns/1ns
`default_nettype none
module swbx_exec_properties
   import swbx_pkg::*;
(
   input wire logic clk,
   input wire logic nrst,
   input wire logic start,
   input wire logic [7:0] opcode,
   input wire logic [14:0] opcode_addr,
   input wire logic status_wr,
   input wire logic busy_r,
   input wire logic done_r,
   input wire logic refused_r,
   input wire swbx_mem_req_type mem_req_r,
   input wire logic iar_load_r,
   input wire logic [14:0] iar_r,
   input wire swbx_status_type status_r
);
   logic [7:0] op_q;
   wire legal = (opcode[7:2] == 6'h1d) || (opcode[7:1] == 7'h5a) || (opcode[6:3] == 4'h3);
   wire accept = start && !busy_r && legal;
   wire op_status = (op_q[7:2] == 6'h1d) || (op_q[7:1] == 7'h5a);
   wire op_test = op_q[7:1] == 7'h5a;
   // opcode of the instruction in flight
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         op_q <= 8'h00;
      end else if (accept) begin
         op_q <= opcode;
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   sequence run_s;
      busy_r [*8] ##1 (done_r && !busy_r);
   endsequence
   sequence fetch_s;
      mem_req_r.rd &&
      (mem_req_r.addr == {$past(opcode_addr[14:13]), $past(opcode_addr[12:0]) + 13'h0001});
   endsequence
   run_length_a: assert property (accept |=> run_s)
      else $error("instruction length wrong");
   first_fetch_a: assert property (accept |=> fetch_s)
      else $error("operand fetch address wrong");
   refuse_busy_a: assert property (start && busy_r |=> refused_r)
      else $error("start while busy not refused");
   refuse_bad_a: assert property (start && !busy_r && !legal |=> refused_r && !busy_r)
      else $error("unsupported opcode not refused");
   upper_unused_a: assert property (status_r.upper[4:3] == 2'h0)
      else $error("unused upper bits set");
   status_hold_a: assert property (!status_wr |=> (status_r == $past(status_r)) || done_r)
      else $error("status changed without cause");
   branch_status_a: assert property (done_r && !op_status |-> $stable(status_r))
      else $error("branch changed status");
   test_cc_only_a: assert property (done_r && op_test |->
      ((status_r & 16'hff3f) == ($past(status_r) & 16'hff3f)))
      else $error("test changed more than condition");
   iar_load_a: assert property (iar_load_r == (done_r && !op_status))
      else $error("address load pulse wrong");
   iar_hold_a: assert property (!iar_load_r |-> $stable(iar_r))
      else $error("address changed without load");
endmodule
bind swbx_exec swbx_exec_properties swbx_exec_properties_inst (.clk, .nrst, .start, .opcode,
   .opcode_addr, .status_wr, .busy_r, .done_r, .refused_r, .mem_req_r, .iar_load_r, .iar_r,
   .status_r);
`default_nettype wire

/* File: sim/swbx_prog_mem.sv */
`timescale 1ns/1ns
`default_nettype none
module swbx_prog_mem
   import swbx_pkg::*;
(
   input wire logic clk,
   input wire swbx_mem_req_type mem_req,
   output var logic [7:0] mem_rdata
);
   logic [7:0] mem [0:32767];
   logic [7:0] data_r = 8'h00;
   logic vld_r = 1'b0;
   // pattern fill so pointer reads return known bytes
   initial begin
      for (int i = 0; i < 32768; i++) begin
         mem[i] = 8'(i * 37) ^ 8'(i >> 7);
      end
   end
   // data valid only in the cycle after a read
   always @(posedge clk) begin
      vld_r <= mem_req.rd;
      if (mem_req.rd) begin
         data_r <= mem[mem_req.addr];
      end
   end
   assign mem_rdata = vld_r ? data_r : ~data_r;
endmodule
`default_nettype wire

/* File: sim/tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
module tb_top import swbx_pkg::*; ;
   logic clk = 1'b0, nrst = 1'b0, start = 1'b0, status_wr = 1'b0;
   logic [7:0] opcode = 8'h00, index_value = 8'h00, mem_rdata;
   logic [14:0] opcode_addr = 15'h0000, iar_r;
   swbx_status_type status_in = 16'h0000, status_r;
   swbx_mem_req_type mem_req_r;
   logic busy_r, done_r, refused_r, iar_load_r;
   int miscompares = 0, tests_run = 0, n;
   logic [7:0] ops [6] = '{8'h74, 8'h75, 8'h76, 8'h77, 8'hb4, 8'hb5};
   always #25 clk = ~clk;
   swbx_exec swbx_exec_inst (.clk, .nrst, .start, .opcode, .opcode_addr, .mem_rdata,
      .index_value, .status_wr, .status_in, .busy_r, .done_r, .refused_r, .mem_req_r,
      .iar_load_r, .iar_r, .status_r);
   swbx_prog_mem swbx_prog_mem_inst (.clk, .mem_req(mem_req_r), .mem_rdata);
   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         miscompares++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic print_verdict;
      $display("comparisons %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   task automatic load_st(input logic [15:0] s);
      status_in = s;
      status_wr = 1'b1;
      @(posedge clk);
      #1 status_wr = 1'b0;
      chk(status_r, s & 16'he7ff);
   endtask
   task automatic run(input logic [7:0] op, input logic [14:0] a, input bit poke);
      opcode = op;
      opcode_addr = a;
      index_value = 8'($urandom);
      start = 1'b1;
      @(posedge clk);
      #1 start = 1'b0;
      n = 0;
      while (done_r !== 1'b1 && n < 20) begin
         @(posedge clk);
         #1 n++;
         if (poke && n == 2) start = 1'b1;
         if (poke && n == 3) begin
            start = 1'b0;
            chk(16'(refused_r), 16'h0001);
         end
      end
      chk(16'(n), 16'h0008);
   endtask
   ////////////////////////////////////////////////////////////////////////////
   function automatic logic [15:0] exp_st(logic [7:0] op, logic [15:0] s, logic [7:0] m);
      logic [7:0] t;
      t = op[0] ? s[7:0] : s[15:8];
      case (op)
         8'h76: s[15:8] = (t | m) & 8'he7;
         8'h77: s[7:0] = t | m;
         8'h74: s[15:8] = t & ~m;
         8'h75: s[7:0] = t & ~m;
         default: s[7:6] = ((t & m) == m) ? 2'h0 : 2'h2;
      endcase
      return s;
   endfunction
   function automatic logic [14:0] exp_br(logic [7:0] op, logic [14:0] a, logic [1:0] cc,
      logic [7:0] x);
      logic [7:0] b1, b2;
      logic [14:0] ea;
      logic hit;
      b1 = swbx_prog_mem_inst.mem[a + 15'h0001];
      b2 = swbx_prog_mem_inst.mem[a + 15'h0002];
      ea = op[2] ? {b1[6:0], b2} : {a[14:13], a[12:0] + 13'h0002 + 13'(signed'(b1[6:0]))};
      if (op == 8'h9b) ea = {2'h0, 13'(signed'(b1[6:0]))};
      if (b1[7]) ea = {swbx_prog_mem_inst.mem[ea][6:0],
         swbx_prog_mem_inst.mem[{ea[14:13], ea[12:0] + 13'h0001}]};
      if (op == 8'h9f) ea = {ea[14:13], ea[12:0] + 13'(x)};
      hit = op[7] ? (op[1:0] != cc) : (op[1:0] == cc);
      if (op[1:0] == 2'h3) hit = 1'b1;
      return hit ? ea : a + (op[2] ? 15'h0003 : 15'h0002);
   endfunction
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      logic [7:0] op, m;
      logic [15:0] s;
      logic [14:0] a;
      void'($urandom(71));
      repeat (16) @(posedge clk);
      chk(status_r, 16'h0000);
      #1 nrst = 1'b1;
      @(posedge clk);
      #1 $display("test reset done");
      for (int k = 0; k < 18; k++) begin
         op = ops[k % 6];
         m = (k < 6) ? 8'hff : (k < 12) ? 8'($urandom) : 8'h18;
         a = {2'($urandom), 13'($urandom % 8000)};
         swbx_prog_mem_inst.mem[a + 15'h0001] = m;
         s = 16'($urandom);
         load_st(s);
         run(op, a, k == 4);
         chk(status_r, exp_st(op, s & 16'he7ff, m));
      end
      $display("test status ops done");
      for (int k = 0; k < 64; k++) begin
         op = 8'(k[2:0]) | (k[3] ? 8'h98 : 8'h18);
         a = {2'($urandom), 13'($urandom % 8000)};
         swbx_prog_mem_inst.mem[a + 15'h0001] = 8'($urandom);
         swbx_prog_mem_inst.mem[a + 15'h0002] = 8'($urandom);
         s = 16'($urandom);
         load_st(s);
         run(op, a, 1'b0);
         chk(16'(iar_load_r), 16'h0001);
         chk(16'(iar_r), 16'(exp_br(op, a, s[7:6], index_value)));
      end
      $display("test branches done");
      opcode = 8'h00;
      start = 1'b1;
      @(posedge clk);
      #1 start = 1'b0;
      chk(16'({refused_r, busy_r}), 16'h0002);
      $display("test refusal done");
      print_verdict;
   end
   initial begin
      repeat (5000) @(posedge clk);
      miscompares++;
      print_verdict;
   end
endmodule
`default_nettype wire
